/* File: shared/rsc_map.vh */
// Register map, field positions, reset values and timing of the reset controller
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSC_OFS_CAUSE 8'h00
`define RSC_OFS_STATUS 8'h01
// ----------------------------------------
// Cause register bit positions
// ----------------------------------------
`define RSC_BIT_PIN 0
`define RSC_BIT_PWR 1
`define RSC_BIT_CLK 2
`define RSC_BIT_CMP 5
`define RSC_BIT_CNV 6
`define RSC_CAUSE_RESET 8'h00
`define RSC_CAUSE_WMASK 8'h66
// ----------------------------------------
// Defaults driven while in reset
// ----------------------------------------
`define RSC_PORT_RESET 8'hFF
`define RSC_PC_RESET 16'h0000
`define RSC_CLKSRC_INTERNAL 2'h0
`define RSC_CLKDIV_LOWEST 3'h7
`define RSC_WDT_LONGEST 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define RSC_CLK_HZ 20000000
`define RSC_SETTLE_MS 100
// Supply settle count: 100 ms at the 20 MHz system clock
`define RSC_SETTLE_CYC 21'h1E8480
`define RSC_PIN_STRETCH_CYC 21'h00000C
`define RSC_CLKLOSS_US 100
`define RSC_CNT_W 21
`endif

/* File: hw/rsc_reset_control.v */
// Reset source gathering, stretching, cause flags and release sequencing
//
// Functional notes
// - Reset halts core, inits registers, ports, timers
// - Data memory untouched; only stack pointer reinit
// - Port latches held at all ones
// - Exit clears PC, selects slowest internal oscillator
// - Watchdog enabled with longest interval on exit
// - Fetch from zero once clock is stable
// - Low supply holds device in reset
// - Supply reset drives pin low until settled
// - Monitor active with enable pin and flag
// - Power-on exit sets the power-on flag
// - Other resets clear the power-on flag
// - Supply dip resets, recovers like power-on
// - Pin reset stretched twelve cycles after release
// - Pin reset exit sets the pin flag
// - Enabled clock loss detector causes reset
// - Clock loss flag one only after it
// - Clock loss reset leaves pin alone
// - Clock loss flag bit doubles as enable
// - Conversion start input low-level reset source
// - Comparator flag one only after comparator reset; here bit 5 is also writable and gates that reset
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "rsc_map.vh"

// ----------------------------------------
// Request holder
// ----------------------------------------
module rsc_req_sync (
  input wire clk,
  input wire req,
  output reg held
);
  reg stage1;

  always @(posedge clk or posedge req) begin
    if (req) begin
      stage1 <= 1'b1;
      held <= 1'b1;
    end else begin
      stage1 <= 1'b0;
      held <= stage1;
    end
  end
endmodule

// ----------------------------------------
// Reset controller top
// ----------------------------------------
module rsc_reset_control #(
  // Settle count sized to the counter so no bits are lost on assignment
  parameter [`RSC_CNT_W-1:0] SETTLE_CYC = `RSC_SETTLE_CYC
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  input wire rstPinIn,
  output reg rstPinOut,
  output reg rstPinDriveN,
  input wire supplyLow,
  input wire monitorEnPin,
  input wire clkLossDetected,
  output wire clkLossDetEn,
  input wire compResetN,
  input wire convStartInN,
  input wire oscStable,
  output reg execHalt,
  output reg sfrInit,
  output reg intTimerOff,
  output reg [7:0] portLatch,
  output reg [15:0] pcValue,
  output reg [1:0] clkSource,
  output reg [2:0] clkDivSel,
  output reg wdtEnable,
  output reg [2:0] wdtInterval,
  output reg fetchStart
);
  localparam ST_HOLD = 2'h0;
  localparam ST_STRETCH = 2'h1;
  localparam ST_CLKWAIT = 2'h2;
  localparam ST_RUN = 2'h3;
  localparam [`RSC_CNT_W-1:0] PIN_CYC = `RSC_PIN_STRETCH_CYC;
  // Cause vector order: pin, supply, clock loss, comparator, conversion start
  localparam C_PIN = 0;
  localparam C_PWR = 1;
  localparam C_CLK = 2;
  localparam C_CMP = 3;
  localparam C_CNV = 4;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [4:0] cause_q;
  reg [4:0] cause_d;
  reg [`RSC_CNT_W-1:0] cnt_q;
  reg [`RSC_CNT_W-1:0] cnt_d;
  reg [7:0] causeReg_q;
  reg [7:0] causeReg_d;
  reg oscMeta;
  reg oscSync;
  reg pinDriveDly_q;
  wire [4:0] held;
  wire [4:0] rawReq;
  wire anyReq;
  wire monGate;
  wire inResetD;

  // ----------------------------------------
  // Request gating and holding
  // ----------------------------------------
  // Monitor kept effective while in reset so a dip during stretch is never missed
  // monitor gated by pin and flag
  assign monGate = causeReg_q[`RSC_BIT_PWR] | execHalt;
  // Pin input ignored while we drive it ourselves, else our own pulse reads as a pin reset
  // The delayed drive copy also blanks the cycle in which we let go, so a pin
  // that has not yet risen in that instant cannot set the pin holder
  // pin low forces reset
  assign rawReq[C_PIN] = ~rstPinIn & rstPinDriveN & pinDriveDly_q;
  assign rawReq[C_PWR] = supplyLow & monitorEnPin & monGate;
  assign rawReq[C_CLK] = clkLossDetected & causeReg_q[`RSC_BIT_CLK];
  assign rawReq[C_CMP] = ~compResetN & causeReg_q[`RSC_BIT_CMP];
  assign rawReq[C_CNV] = ~convStartInN & causeReg_q[`RSC_BIT_CNV];
  // The detector one-shot itself is analog; its timeout is RSC_CLKLOSS_US
  assign clkLossDetEn = causeReg_q[`RSC_BIT_CLK];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_req
      rsc_req_sync u_sync (
        .clk(clk_sys),
        .req(rawReq[gi]),
        .held(held[gi])
      );
    end
  endgenerate

  assign anyReq = |held;

  // Oscillator stable flag comes from another domain
  always @(posedge clk_sys) begin
    if (!rstn) begin
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
    end else begin
      oscMeta <= oscStable;
      oscSync <= oscMeta;
    end
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cause_d = cause_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RUN: begin
        if (anyReq) begin
          state_d = ST_HOLD;
          cause_d = held;
        end
      end
      ST_HOLD: begin
        cause_d = cause_q | held;
        if (!anyReq) begin
          state_d = ST_STRETCH;
          if (cause_d[C_PWR]) begin
            cnt_d = SETTLE_CYC - 1'b1;
          end else begin
            cnt_d = PIN_CYC - 1'b1;
          end
        end
      end
      ST_STRETCH: begin
        if (anyReq) begin
          state_d = ST_HOLD;
          cause_d = cause_q | held;
        end else if (cnt_q == {`RSC_CNT_W{1'b0}}) begin
          state_d = ST_CLKWAIT;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_CLKWAIT: begin
        if (anyReq) begin
          state_d = ST_HOLD;
          cause_d = cause_q | held;
        end else if (oscSync) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  assign inResetD = (state_d != ST_RUN);

  // ----------------------------------------
  // Cause register next value
  // ----------------------------------------
  // Hardware updates win over a software write in the same cycle
  always @* begin
    causeReg_d = causeReg_q;
    if (regWr && regAddr == `RSC_OFS_CAUSE) begin
      causeReg_d = (causeReg_q & ~`RSC_CAUSE_WMASK) | (regWrData & `RSC_CAUSE_WMASK);
    end
    if (state_q == ST_RUN && state_d != ST_RUN) begin
      causeReg_d = `RSC_CAUSE_RESET;
    end else if (state_q != ST_RUN && state_d == ST_RUN) begin
      causeReg_d = `RSC_CAUSE_RESET;
      causeReg_d[`RSC_BIT_PWR] = cause_q[C_PWR];
      causeReg_d[`RSC_BIT_PIN] = cause_q[C_PIN];
      causeReg_d[`RSC_BIT_CLK] = cause_q[C_CLK];
      causeReg_d[`RSC_BIT_CMP] = cause_q[C_CMP];
      causeReg_d[`RSC_BIT_CNV] = cause_q[C_CNV];
    end
  end

  // ----------------------------------------
  // State and register flops
  // ----------------------------------------
  // Synchronous reset is treated as power-on: supply cause and settle stretch
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ST_HOLD;
      cause_q <= 5'h02;
      cnt_q <= {`RSC_CNT_W{1'b0}};
      causeReg_q <= `RSC_CAUSE_RESET;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      cnt_q <= cnt_d;
      causeReg_q <= causeReg_d;
    end
  end

  // ----------------------------------------
  // Reset pin drive
  // ----------------------------------------
  // drive low on supply cause; other causes leave it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rstPinOut <= 1'b0;
      rstPinDriveN <= 1'b0;
    end else begin
      rstPinOut <= 1'b0;
      rstPinDriveN <= ~((state_d == ST_HOLD || state_d == ST_STRETCH) & cause_d[C_PWR]);
    end
  end

  // One-cycle delayed pin drive, used to blank our own release edge
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pinDriveDly_q <= 1'b0;
    end else begin
      pinDriveDly_q <= rstPinDriveN;
    end
  end

  // ----------------------------------------
  // Core control outputs
  // ----------------------------------------
  // Defaults reload every cycle in reset; after release the core owns these
  always @(posedge clk_sys) begin
    if (!rstn || inResetD) begin
      // halt core, init registers, stop timers
      execHalt <= 1'b1;
      intTimerOff <= 1'b1;
      // stack pointer init only, no RAM clear
      sfrInit <= 1'b1;
      portLatch <= `RSC_PORT_RESET;
      pcValue <= `RSC_PC_RESET;
      clkSource <= `RSC_CLKSRC_INTERNAL;
      clkDivSel <= `RSC_CLKDIV_LOWEST;
      wdtEnable <= 1'b1;
      wdtInterval <= `RSC_WDT_LONGEST;
    end else begin
      execHalt <= 1'b0;
      intTimerOff <= 1'b0;
      sfrInit <= 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      fetchStart <= 1'b0;
    end else begin
      fetchStart <= (state_q == ST_CLKWAIT) && (state_d == ST_RUN);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Data valid only in the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `RSC_OFS_CAUSE: begin
          regRdData <= causeReg_q;
        end
        `RSC_OFS_STATUS: begin
          regRdData <= {2'h0, held[4:2], oscSync, state_q};
        end
        default: begin
          regRdData <= 8'h00;
        end
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

/* File: verification/rsc_pin_model.sv */
// Reset pin model: board pull-up plus an outside reset driver
`timescale 1ns/1ps
module rsc_pin_model (
  input wire rstPinDriveN,
  input wire extLow,
  output wire rstPinIn
);
  // pull-up, wired low
  // The pull-up wins while neither side pulls low, and also before the device's drive is known
  assign rstPinIn = ~extLow & (rstPinDriveN !== 1'b0);
endmodule

/* File: verification/rsc_reset_control_assertions.sv */
// Port checker for the reset controller, bound to its top module
`timescale 1ns/1ps
module rsc_reset_control_assertions #(
  parameter [20:0] SETTLE_CYC = 21'd20
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  input wire rstPinIn,
  input wire rstPinDriveN,
  input wire supplyLow,
  input wire monitorEnPin,
  input wire clkLossDetected,
  input wire clkLossDetEn,
  input wire compResetN,
  input wire convStartInN,
  input wire execHalt,
  input wire sfrInit,
  input wire intTimerOff,
  input wire [7:0] portLatch,
  input wire [15:0] pcValue,
  input wire [1:0] clkSource,
  input wire [2:0] clkDivSel,
  input wire wdtEnable,
  input wire [2:0] wdtInterval,
  input wire fetchStart
);
  logic [7:0] pinCnt_q;
  logic [20:0] supCnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----
  // Helper counters
  // ----
  // Cycles since outside logic last held the pin low
  always @(posedge clk_sys) begin
    if (!rstn || (!rstPinIn && rstPinDriveN)) pinCnt_q <= 8'h00;
    else if (pinCnt_q != 8'hFF) pinCnt_q <= pinCnt_q + 8'h01;
  end
  // Cycles since a low supply was last seen; saturates so it never wraps
  always @(posedge clk_sys) begin
    if (!rstn || (supplyLow && monitorEnPin)) supCnt_q <= 21'h000000;
    else if (supCnt_q != 21'h1FFFFF) supCnt_q <= supCnt_q + 21'h000001;
  end
  // ----
  // Properties
  // ----
  sequence s_run;
    $fell(execHalt) ##0 fetchStart;
  endsequence
  a_halt_init: assert property (execHalt |-> sfrInit && intTimerOff)
    else $error("init flags low while halted");
  a_fetch_exit: assert property (fetchStart |-> s_run)
    else $error("fetch start without leaving reset");
  a_fetch_pulse: assert property (fetchStart |=> !fetchStart)
    else $error("fetch start longer than one cycle");
  a_exit_dflt: assert property (s_run |-> portLatch == 8'hFF
      && pcValue == 16'h0000 && clkSource == 2'h0 && clkDivSel == 3'h7
      && wdtEnable && wdtInterval == 3'h7)
    else $error("wrong defaults at release");
  a_pin_stretch: assert property (fetchStart |-> pinCnt_q >= 8'h0C)
    else $error("released too soon after pin reset");
  a_settle_len: assert property ($rose(rstPinDriveN)
      |-> supCnt_q >= SETTLE_CYC - 21'h000001)
    else $error("pin released before settle time");
  a_supply_hold: assert property (execHalt && supplyLow && monitorEnPin
      |-> ##[1:3] (execHalt && !rstPinDriveN))
    else $error("low supply not holding reset");
  a_loss_pin: assert property (clkLossDetected && rstPinDriveN && !supplyLow
      && !$past(supplyLow) |=> rstPinDriveN)
    else $error("clock loss drove the pin");
  a_loss_enable: assert property (regWr && regAddr == 8'h00 && !execHalt && rstPinIn
      && !supplyLow
      && !clkLossDetected && compResetN && convStartInN |=> clkLossDetEn == $past(regWrData[2]))
    else $error("detector enable does not follow write");
  a_unmapped_rd: assert property (regRd && regAddr > 8'h01 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind rsc_reset_control rsc_reset_control_assertions #(.SETTLE_CYC(SETTLE_CYC))
  i_rsc_reset_control_assertions (.*);

/* File: verification/rsc_reset_control_tb.sv */
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module rsc_reset_control_tb;
  localparam int SETTLE = 20;
  logic clk_sys, rstn, regWr, regRd, supplyLow, supply_monitor_enable_pin, clkLoss, compN, convN, osc, extLow;
  logic execHalt, fetchStart, pinDriveN, lossEn, pinLevel;
  logic [7:0] regAddr, regWrData, regRdData, portLatch, prev;
  logic [15:0] pcValue;
  logic [2:0] clkDivSel, wdtInterval;
  logic [7:0] maskTab [3] = '{8'h06, 8'h22, 8'h42};
  int badCount = 0, checked = 0, cyc = 0, n;
  rsc_reset_control #(.SETTLE_CYC(21'd20)) i_rsc_reset_control (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rstPinIn(pinLevel),
    .rstPinOut(), .rstPinDriveN(pinDriveN), .supplyLow(supplyLow), .monitorEnPin(supply_monitor_enable_pin),
    .clkLossDetected(clkLoss), .clkLossDetEn(lossEn), .compResetN(compN),
    .convStartInN(convN), .oscStable(osc), .execHalt(execHalt), .sfrInit(), .intTimerOff(),
    .portLatch(portLatch), .pcValue(pcValue), .clkSource(), .clkDivSel(clkDivSel),
    .wdtEnable(), .wdtInterval(wdtInterval), .fetchStart(fetchStart));
  rsc_pin_model i_rsc_pin_model (.rstPinDriveN(pinDriveN), .extLow(extLow), .rstPinIn(pinLevel));
  // ----
  // Clock, timeout and tasks
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Cuts a hang short; the tests need a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      badCount++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // Bounded wait for the release pulse; n ends at lim when it never came
  task automatic wait_run(input int lim);
    n = 0;
    while (fetchStart !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic src(input int i, input logic v);
    @(posedge clk_sys);
    clkLoss <= v && i == 0;
    compN <= !(v && i == 1);
    convN <= !(v && i == 2);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    {regWr, regRd, supplyLow, clkLoss, extLow, rstn} = 6'h00;
    {supply_monitor_enable_pin, compN, convN, osc} = 4'hF;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_run(500);
    chk(n >= SETTLE && n < 500, 16'h0001);
    chk({portLatch, pcValue[7:0]}, 16'hFF00);
    chk({clkDivSel, wdtInterval}, 16'h003F);
    rdChk(8'h00, 8'h02);
    // Status: run state, clock stable, no clock loss, comparator or conversion request held
    rdChk(8'h01, 8'h07);
    rdChk(8'h05, 8'h00);
    $display("test power-on done");
    @(posedge clk_sys);
    extLow <= 1'b1;
    settle(4);
    chk({execHalt, portLatch}, 16'h01FF);
    @(posedge clk_sys);
    extLow <= 1'b0;
    wait_run(500);
    chk(n >= 12 && n < 500, 16'h0001);
    rdChk(8'h00, 8'h01);
    $display("test pin reset done");
    // Clock loss, comparator and conversion start in turn; bit 0 is read-only
    // A write replaces bits 1, 2, 5 and 6 and keeps the rest
    prev = 8'h01;
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, maskTab[i]);
      rdChk(8'h00, (prev & 8'h99) | maskTab[i]);
      chk(lossEn, maskTab[i][2]);
      src(i, 1'b1);
      settle(4);
      chk({execHalt, pinDriveN}, 16'h0003);
      src(i, 1'b0);
      wait_run(500);
      prev = maskTab[i] & 8'h64;
      rdChk(8'h00, prev);
    end
    $display("test source table done");
    @(posedge clk_sys);
    supplyLow <= 1'b1;
    settle(4);
    chk(execHalt, 16'h0000);
    @(posedge clk_sys);
    supplyLow <= 1'b0;
    // Monitor enable drops first so the next supply edge never meets it high
    supply_monitor_enable_pin <= 1'b0;
    wr(8'h00, 8'h02);
    @(posedge clk_sys);
    supplyLow <= 1'b1;
    settle(4);
    chk(execHalt, 16'h0000);
    @(posedge clk_sys);
    supply_monitor_enable_pin <= 1'b1;
    osc <= 1'b0;
    settle(4);
    chk({execHalt, pinDriveN}, 16'h0002);
    @(posedge clk_sys);
    supplyLow <= 1'b0;
    wait_run(60);
    chk(n, 16'h003C);
    @(posedge clk_sys);
    osc <= 1'b1;
    wait_run(500);
    chk(n < 500, 16'h0001);
    rdChk(8'h00, 8'h02);
    $display("test supply reset done");
    end_of_test();
  end
endmodule
